// ==== verilog/lbd_regs.svh ====
`ifndef LBD_REGS_SVH
`define LBD_REGS_SVH
// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define LBD_HASH_CTRL 8'h00
`define LBD_MIR_SRC 8'h04
`define LBD_MIR_DST 8'h08
`define LBD_STATUS 8'h0C
`define LBD_PORT_MAP 8'h10
`define LBD_BND_CFG 8'h40
`define LBD_BND_STAT 8'h60
// ----------------------------------------
// Fields and reset values
// ----------------------------------------
`define LBD_HASH_RST 4'hD
`define LBD_NO_BUNDLE 4'hF
`define LBD_CFG_TYPE 0
`define LBD_CFG_USE_LSB 4
`define LBD_USE_RST 4'h8
`define LBD_STAT_ERR 0
`define LBD_STAT_AGG_LSB 16
`define LBD_STAT_CFG_LSB 4
`define LBD_RESP_OK 2'h0
`define LBD_RESP_SLVERR 2'h2
`endif

// ==== verilog/lbd_pkg.sv ====
package lbd_pkg;
  typedef struct packed {
    logic [47:0] smac;
    logic [47:0] dmac;
    logic [31:0] sip;
    logic [31:0] dip;
    logic [15:0] sport;
    logic [15:0] dport;
    logic ipv4;
    logic l4;
  } lbd_hdr_t;

  typedef struct packed {
    logic l4;
    logic ip;
    logic dmac;
    logic smac;
  } lbd_hash_en_t;

  typedef enum logic [1:0] {
    LBD_SPD_10 = 2'h0,
    LBD_SPD_100 = 2'h1,
    LBD_SPD_1G = 2'h2,
    LBD_SPD_NONE = 2'h3
  } lbd_speed_t;
endpackage : lbd_pkg

// ==== verilog/lbd_hash.sv ====
`timescale 1ns/1ns
module lbd_hash (
  // Frame fields and enables
  input lbd_pkg::lbd_hdr_t hdr,
  input lbd_pkg::lbd_hash_en_t en,
  // Flow code
  output logic [15:0] code
);
  function automatic logic [15:0] fold48(input logic [47:0] v);
    return v[47:32] ^ v[31:16] ^ v[15:0];
  endfunction : fold48

  wire use_ip = en.ip & hdr.ipv4;
  // Port numbers only count for IPv4 TCP/UDP
  wire use_l4 = en.l4 & hdr.ipv4 & hdr.l4;
  wire [15:0] c_smac = en.smac ? fold48(hdr.smac) : 16'h0000;
  wire [15:0] c_dmac = en.dmac ? fold48(hdr.dmac) : 16'h0000;
  wire [15:0] c_ip = use_ip ?
    (hdr.sip[31:16] ^ hdr.sip[15:0] ^ hdr.dip[31:16] ^ hdr.dip[15:0]) : 16'h0000;
  wire [15:0] c_l4 = use_l4 ? (hdr.sport ^ hdr.dport) : 16'h0000;
  // Pure function of flow fields; all off gives zero
  assign code = c_smac ^ c_dmac ^ c_ip ^ c_l4;
endmodule : lbd_hash

// ==== verilog/lbd_pick.sv ====
`timescale 1ns/1ns
module lbd_pick #(
  parameter int NP = 12,
  parameter int PW = 4
) (
  // Code and candidates
  input logic [15:0] code,
  input logic [NP-1:0] mask,
  // Choice
  output logic [PW-1:0] port,
  output logic found
);
  logic [15:0] cnt;
  logic [15:0] idx;
  logic [15:0] k;

  always_comb begin
    cnt = 16'h0000;
    for (int i = 0; i < NP; i++) begin
      cnt = cnt + 16'(mask[i]);
    end
    idx = (cnt == 16'h0000) ? 16'h0000 : (code % cnt);
    port = '0;
    k = 16'h0000;
    for (int i = 0; i < NP; i++) begin
      if (mask[i]) begin
        if (k == idx) begin
          port = PW'(i);
        end
        k = k + 16'h0001;
      end
    end
    found = (cnt != 16'h0000);
  end
endmodule : lbd_pick

// ==== verilog/lbd_top.sv ====
`timescale 1ns/1ns
`include "lbd_regs.svh"
module lbd_top #(
  parameter int NP = 12,
  parameter int NB = 5,
  parameter int MAXM = 10
) (
  // System
  input logic SYS_CLK,
  input logic RESET_N,
  // AXI4-Lite slave
  input logic [7:0] S_AXI_AWADDR,
  input logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input logic [31:0] S_AXI_WDATA,
  input logic [3:0] S_AXI_WSTRB,
  input logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input logic S_AXI_BREADY,
  input logic [7:0] S_AXI_ARADDR,
  input logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input logic S_AXI_RREADY,
  // Member port state
  input logic [NP-1:0] PORT_LINK_UP,
  input logic [NP-1:0] PORT_FULL_DUP,
  input logic [2*NP-1:0] PORT_SPEED,
  // Frame to a bundle
  input logic FRM_VALID,
  input lbd_pkg::lbd_hdr_t FRM_HDR,
  input logic [2:0] FRM_BUNDLE,
  // Member choice
  output logic SEL_VALID,
  output logic [3:0] SEL_PORT,
  output logic SEL_DROP,
  // Logical port view
  output logic [NB-1:0] BND_UP,
  output logic [NP-1:0] PORT_IN_BND
);
  localparam int PW = 4;
  localparam int BW = 3;
  localparam logic [7:0] PM_END = 8'(`LBD_PORT_MAP + 4 * NP);
  localparam logic [7:0] BC_END = 8'(`LBD_BND_CFG + 4 * NB);
  localparam logic [7:0] BS_END = 8'(`LBD_BND_STAT + 4 * NB);

  // Declared first so the checks inside the generate loops see them
  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (!RESET_N);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [4:0] popc(input logic [NP-1:0] m);
    popc = 5'h00;
    for (int i = 0; i < NP; i++) begin
      popc = popc + 5'(m[i]);
    end
  endfunction : popc

  function automatic logic [NP-1:0] first_n(input logic [NP-1:0] m,
                                            input logic [3:0] n);
    logic [3:0] k;
    first_n = '0;
    k = 4'h0;
    for (int i = 0; i < NP; i++) begin
      if (m[i] && k < n) begin
        first_n[i] = 1'b1;
        k = k + 4'h1;
      end
    end
  endfunction : first_n

  function automatic lbd_pkg::lbd_speed_t bnd_speed(input logic [NP-1:0] m,
                                                    input logic [NP-1:0] up,
                                                    input logic [2*NP-1:0] sp);
    logic f;
    bnd_speed = lbd_pkg::LBD_SPD_NONE;
    f = 1'b0;
    for (int i = 0; i < NP; i++) begin
      if (m[i] && up[i] && !f) begin
        bnd_speed = lbd_pkg::lbd_speed_t'(sp[2*i +: 2]);
        f = 1'b1;
      end
    end
  endfunction : bnd_speed

  // ----------------------------------------
  // Register state
  // ----------------------------------------
  lbd_pkg::lbd_hash_en_t hash_en_q;
  logic [NP-1:0] mir_src_q;
  logic [NP-1:0] mir_dst_q;
  logic err_q;
  logic [3:0] pmap_q [NP];
  logic [NB-1:0] btype_q;
  logic [3:0] buse_q [NB];

  // ----------------------------------------
  // AXI4-Lite handshake
  // ----------------------------------------
  logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
  logic have_aw_q, have_w_q;
  logic [7:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic [1:0] bresp_q, rresp_q;
  logic [31:0] rdata_q;

  wire aw_take = S_AXI_AWVALID & awready_q;
  wire w_take = S_AXI_WVALID & wready_q;
  wire wr_fire = have_aw_q & have_w_q & ~bvalid_q;
  wire have_aw_d = (have_aw_q | aw_take) & ~wr_fire;
  wire have_w_d = (have_w_q | w_take) & ~wr_fire;
  wire bvalid_d = wr_fire | (bvalid_q & ~S_AXI_BREADY);
  wire ar_take = S_AXI_ARVALID & arready_q;
  wire rvalid_d = ar_take | (rvalid_q & ~S_AXI_RREADY);

  // ----------------------------------------
  // Write decode
  // ----------------------------------------
  wire [7:0] wa = aw_addr_q;
  wire wa_al = (wa[1:0] == 2'h0);
  wire wa_hash = (wa == `LBD_HASH_CTRL);
  wire wa_msrc = (wa == `LBD_MIR_SRC);
  wire wa_mdst = (wa == `LBD_MIR_DST);
  wire wa_stat = (wa == `LBD_STATUS);
  wire wa_pm = wa_al && wa >= `LBD_PORT_MAP && wa < PM_END;
  wire wa_bc = wa_al && wa >= `LBD_BND_CFG && wa < BC_END;
  wire [PW-1:0] w_pidx = PW'((wa - `LBD_PORT_MAP) >> 2);
  wire [BW-1:0] w_bidx = BW'((wa - `LBD_BND_CFG) >> 2);
  wire wa_ok = wa_hash | wa_msrc | wa_mdst | wa_stat | wa_pm | wa_bc;
  wire [31:0] wmask = {{8{w_strb_q[3]}}, {8{w_strb_q[2]}},
                       {8{w_strb_q[1]}}, {8{w_strb_q[0]}}};
  wire [NP-1:0] msrc_new = NP'((32'(mir_src_q) & ~wmask) | (w_data_q & wmask));
  wire [NP-1:0] mdst_new = NP'((32'(mir_dst_q) & ~wmask) | (w_data_q & wmask));

  // ----------------------------------------
  // Bundle membership and aggregation
  // ----------------------------------------
  logic [NB-1:0][NP-1:0] cfg_m;
  logic [NB-1:0][NP-1:0] agg_m;
  logic [NB-1:0][31:0] bstat;
  lbd_pkg::lbd_speed_t bspd [NB];
  logic [NP-1:0] port_in;
  logic [NP-1:0] pm_rej;
  wire [NP-1:0] fd_up = PORT_LINK_UP & PORT_FULL_DUP;

  genvar b, p;
  generate
    for (b = 0; b < NB; b++) begin : g_bnd
      logic [NP-1:0] elig;
      logic [NP-1:0] spd_ok;
      for (p = 0; p < NP; p++) begin : g_mem
        assign cfg_m[b][p] = (pmap_q[p] == 4'(b));
        assign spd_ok[p] = (PORT_SPEED[2*p +: 2] == bspd[b]);
      end
      assign bspd[b] = bnd_speed(cfg_m[b], PORT_LINK_UP, PORT_SPEED);
      assign elig = cfg_m[b] & fd_up & spd_ok;
      // Port order decides who is standby; a failed member frees a slot
      assign agg_m[b] = btype_q[b] ? first_n(elig, buse_q[b]) : elig;
      assign bstat[b] = (32'(agg_m[b]) << `LBD_STAT_AGG_LSB) |
                        (32'(cfg_m[b]) << `LBD_STAT_CFG_LSB) |
                        32'({bspd[b], btype_q[b]});

      always_ff @(posedge SYS_CLK) begin
        if (!RESET_N) begin
          btype_q[b] <= 1'b0;
          buse_q[b] <= `LBD_USE_RST;
        end else if (wr_fire && wa_bc && w_bidx == BW'(b) && w_strb_q[0]) begin
          btype_q[b] <= w_data_q[`LBD_CFG_TYPE];
          buse_q[b] <= w_data_q[`LBD_CFG_USE_LSB +: 4];
        end
      end

      cap_members_a: assert property (popc(cfg_m[b]) <= 5'(MAXM))
        else $error("bundle exceeds member limit");
      agg_healthy_a: assert property ((agg_m[b] & ~(fd_up & cfg_m[b])) == '0)
        else $error("aggregated member not eligible");
      standby_cap_a: assert property (btype_q[b] |-> popc(agg_m[b]) <= 5'(buse_q[b]))
        else $error("negotiated bundle over usable count");
    end

    for (p = 0; p < NP; p++) begin : g_port
      logic [3:0] nv;
      logic [NP-1:0] others;
      logic ok;
      logic we;
      assign nv = w_strb_q[0] ? w_data_q[3:0] : pmap_q[p];
      assign others = ((nv < 4'(NB)) ? cfg_m[BW'(nv)] : '0) & ~(NP'(1) << p);
      assign ok = (nv == `LBD_NO_BUNDLE) ||
                  (nv < 4'(NB) && !mir_src_q[p] && !mir_dst_q[p] &&
                   popc(others) < 5'(MAXM));
      assign we = wr_fire & wa_pm & (w_pidx == PW'(p));
      assign pm_rej[p] = we & ~ok;
      assign port_in[p] = (pmap_q[p] != `LBD_NO_BUNDLE);

      always_ff @(posedge SYS_CLK) begin
        if (!RESET_N) begin
          pmap_q[p] <= `LBD_NO_BUNDLE;
        end else if (we && ok) begin
          pmap_q[p] <= nv;
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // Global control registers
  // ----------------------------------------
  wire msrc_rej = wr_fire & wa_msrc & |(msrc_new & port_in);
  wire mdst_rej = wr_fire & wa_mdst & |(mdst_new & port_in);
  wire err_set = |pm_rej | msrc_rej | mdst_rej;
  wire err_clr = wr_fire & wa_stat & w_strb_q[0] & w_data_q[`LBD_STAT_ERR];
  // New rejection in the clearing cycle still lands
  wire err_d = err_set | (err_q & ~err_clr);

  always_ff @(posedge SYS_CLK) begin
    if (!RESET_N) begin
      hash_en_q <= lbd_pkg::lbd_hash_en_t'(`LBD_HASH_RST);
      mir_src_q <= '0;
      mir_dst_q <= '0;
      err_q <= 1'b0;
    end else begin
      if (wr_fire && wa_hash && w_strb_q[0]) begin
        hash_en_q <= lbd_pkg::lbd_hash_en_t'(w_data_q[3:0]);
      end
      if (wr_fire && wa_msrc && !msrc_rej) begin
        mir_src_q <= msrc_new;
      end
      if (wr_fire && wa_mdst && !mdst_rej) begin
        mir_dst_q <= mdst_new;
      end
      err_q <= err_d;
    end
  end

  // ----------------------------------------
  // Read decode
  // ----------------------------------------
  wire [7:0] ra = S_AXI_ARADDR;
  wire ra_al = (ra[1:0] == 2'h0);
  wire ra_pm = ra_al && ra >= `LBD_PORT_MAP && ra < PM_END;
  wire ra_bc = ra_al && ra >= `LBD_BND_CFG && ra < BC_END;
  wire ra_bs = ra_al && ra >= `LBD_BND_STAT && ra < BS_END;
  wire [PW-1:0] r_pidx = PW'((ra - `LBD_PORT_MAP) >> 2);
  wire [BW-1:0] r_cidx = BW'((ra - `LBD_BND_CFG) >> 2);
  wire [BW-1:0] r_sidx = BW'((ra - `LBD_BND_STAT) >> 2);
  wire ra_ok = (ra == `LBD_HASH_CTRL) | (ra == `LBD_MIR_SRC) |
               (ra == `LBD_MIR_DST) | (ra == `LBD_STATUS) | ra_pm | ra_bc | ra_bs;
  wire [31:0] rd_word =
    (ra == `LBD_HASH_CTRL) ? 32'(hash_en_q) :
    (ra == `LBD_MIR_SRC) ? 32'(mir_src_q) :
    (ra == `LBD_MIR_DST) ? 32'(mir_dst_q) :
    (ra == `LBD_STATUS) ? 32'(err_q) :
    ra_pm ? 32'(pmap_q[r_pidx]) :
    ra_bc ? (32'(buse_q[r_cidx]) << `LBD_CFG_USE_LSB) | 32'(btype_q[r_cidx]) :
    ra_bs ? bstat[r_sidx] : 32'h0000_0000;

  always_ff @(posedge SYS_CLK) begin
    if (!RESET_N) begin
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      have_aw_q <= 1'b0;
      have_w_q <= 1'b0;
      bvalid_q <= 1'b0;
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
    end else begin
      awready_q <= ~have_aw_d & ~bvalid_d;
      wready_q <= ~have_w_d & ~bvalid_d;
      have_aw_q <= have_aw_d;
      have_w_q <= have_w_d;
      bvalid_q <= bvalid_d;
      arready_q <= ~rvalid_d;
      rvalid_q <= rvalid_d;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RESET_N) begin
      aw_addr_q <= 8'h00;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
      bresp_q <= `LBD_RESP_OK;
      rresp_q <= `LBD_RESP_OK;
      rdata_q <= 32'h0000_0000;
    end else begin
      if (aw_take) aw_addr_q <= S_AXI_AWADDR;
      if (w_take) w_data_q <= S_AXI_WDATA;
      if (w_take) w_strb_q <= S_AXI_WSTRB;
      if (wr_fire) bresp_q <= wa_ok ? `LBD_RESP_OK : `LBD_RESP_SLVERR;
      if (ar_take) rresp_q <= ra_ok ? `LBD_RESP_OK : `LBD_RESP_SLVERR;
      if (ar_take) rdata_q <= rd_word;
    end
  end

  // ----------------------------------------
  // Member selection
  // ----------------------------------------
  logic [15:0] flow_code;
  logic [PW-1:0] pick_port;
  logic pick_found;
  wire bnd_ok = (FRM_BUNDLE < 3'(NB));
  wire [NP-1:0] frm_mask = bnd_ok ? agg_m[BW'(FRM_BUNDLE)] : '0;

  lbd_hash u_hash (
    .hdr(FRM_HDR),
    .en(hash_en_q),
    .code(flow_code)
  );

  lbd_pick #(.NP(NP), .PW(PW)) u_pick (
    .code(flow_code),
    .mask(frm_mask),
    .port(pick_port),
    .found(pick_found)
  );

  logic sel_valid_q, sel_drop_q;
  logic [3:0] sel_port_q;
  logic [NB-1:0] bnd_up_q;
  logic [NP-1:0] port_in_q;
  logic [NP-1:0] sel_mask_q;

  always_ff @(posedge SYS_CLK) begin
    if (!RESET_N) begin
      sel_valid_q <= 1'b0;
      sel_drop_q <= 1'b0;
      sel_port_q <= 4'h0;
      bnd_up_q <= '0;
      port_in_q <= '0;
      sel_mask_q <= '0;
    end else begin
      sel_valid_q <= FRM_VALID;
      sel_drop_q <= FRM_VALID & ~pick_found;
      sel_port_q <= 4'(pick_port);
      for (int i = 0; i < NB; i++) begin
        bnd_up_q[i] <= |agg_m[i];
      end
      port_in_q <= port_in;
      sel_mask_q <= frm_mask;
    end
  end

  assign S_AXI_AWREADY = awready_q;
  assign S_AXI_WREADY = wready_q;
  assign S_AXI_BVALID = bvalid_q;
  assign S_AXI_BRESP = bresp_q;
  assign S_AXI_ARREADY = arready_q;
  assign S_AXI_RVALID = rvalid_q;
  assign S_AXI_RRESP = rresp_q;
  assign S_AXI_RDATA = rdata_q;
  assign SEL_VALID = sel_valid_q;
  assign SEL_DROP = sel_drop_q;
  assign SEL_PORT = sel_port_q;
  assign BND_UP = bnd_up_q;
  assign PORT_IN_BND = port_in_q;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  same_flow_a: assert property (FRM_VALID ##1 (FRM_VALID && $stable(FRM_HDR) &&
      $stable(FRM_BUNDLE) && $stable(agg_m) && $stable(hash_en_q))
      |-> ##1 (SEL_PORT == $past(SEL_PORT)))
    else $error("one flow moved to another member");
  hash_reset_a: assert property ($rose(RESET_N) |-> hash_en_q == 4'hD)
    else $error("hash enables wrong after reset");
  map_reset_a: assert property ($rose(RESET_N) |-> port_in == '0 ##1 PORT_IN_BND == '0)
    else $error("port in a bundle after reset");
  mirror_excl_a: assert property (((mir_src_q | mir_dst_q) & port_in) == '0)
    else $error("mirror port is a bundle member");
  err_sticky_a: assert property (err_set |=> err_q [*2] or (err_q ##1 $fell(err_q)))
    else $error("rejection not flagged");
  sel_member_a: assert property (SEL_VALID && !SEL_DROP |-> sel_mask_q[SEL_PORT])
    else $error("chosen port not an active member");
  sel_drop_a: assert property (SEL_VALID |-> SEL_DROP == (sel_mask_q == '0))
    else $error("drop flag disagrees with member set");
  fixed_pick_a: assert property (FRM_VALID && hash_en_q == 4'h0 && frm_mask[0]
      |=> SEL_PORT == 4'h0)
    else $error("no fixed member with hashing off");
  bus_resp_a: assert property (wr_fire |=> S_AXI_BVALID && !S_AXI_AWREADY)
    else $error("write response missing");

  write_c: cover property (wr_fire && wa_pm);
  reject_c: cover property (err_set);
  spread_c: cover property (SEL_VALID && !SEL_DROP && SEL_PORT != 4'h0);
  drop_c: cover property (SEL_VALID && SEL_DROP);
endmodule : lbd_top

// ==== sim/lbd_port_model.sv ====
`timescale 1ns/1ns
// ----
// Member ports and peer switch
// ----
module lbd_port_model #(
  parameter int NP = 12
) (
  // Control
  input logic clk,
  input logic cabled,
  input logic [NP-1:0] fail,
  input logic [NP-1:0] half,
  input logic [NP-1:0] slow,
  // Port state
  output logic [NP-1:0] link_up,
  output logic [NP-1:0] full_dup,
  output logic [2*NP-1:0] speed
);
  // No link until the peer is cabled, so bundles exist on both ends first
  always_ff @(posedge clk) begin
    for (int i = 0; i < NP; i++) begin
      link_up[i] <= cabled && !fail[i];
      full_dup[i] <= cabled && !half[i];
      speed[2*i +: 2] <= !cabled ? 2'h3 : (slow[i] ? 2'h1 : 2'h2);
    end
  end
endmodule : lbd_port_model

// ==== sim/link_bundle_distributor_tb_top.sv ====
`timescale 1ns/1ns
`include "lbd_regs.svh"
module link_bundle_distributor_tb_top;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, sel_valid, sel_drop;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [11:0] link_up, full_dup, port_in_bnd;
  logic [23:0] speed;
  logic frm_valid = 1'b0;
  lbd_pkg::lbd_hdr_t frm_hdr = '0;
  logic [2:0] frm_bundle = 3'h0;
  logic [3:0] sel_port;
  logic [4:0] bnd_up;
  logic cabled = 1'b0;
  logic [11:0] fail = 12'h0, half = 12'h0, slow = 12'h0;
  int fail_count = 0;
  int n_compared = 0;

  always #25 sys_clk = ~sys_clk;

  lbd_port_model i_peer (.clk(sys_clk), .cabled(cabled), .fail(fail), .half(half),
    .slow(slow), .link_up(link_up), .full_dup(full_dup), .speed(speed));

  lbd_top i_dut (.SYS_CLK(sys_clk), .RESET_N(reset_n),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
    .PORT_LINK_UP(link_up), .PORT_FULL_DUP(full_dup), .PORT_SPEED(speed),
    .FRM_VALID(frm_valid), .FRM_HDR(frm_hdr), .FRM_BUNDLE(frm_bundle),
    .SEL_VALID(sel_valid), .SEL_PORT(sel_port), .SEL_DROP(sel_drop),
    .BND_UP(bnd_up), .PORT_IN_BND(port_in_bnd));

  // ----
  // Helpers
  // ----
  task automatic report_and_stop();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : report_and_stop

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge sys_clk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk("bresp", {30'h0, er}, {30'h0, bresp});
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge sys_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
    chk("rdata", ed, rdata);
    chk("rresp", {30'h0, er}, {30'h0, rresp});
  endtask : rd

  task automatic sel(input logic [2:0] b, input lbd_pkg::lbd_hdr_t h, input logic [3:0] ep,
                     input logic ed);
    @(posedge sys_clk);
    frm_valid <= 1'b1;
    frm_hdr <= h;
    frm_bundle <= b;
    @(posedge sys_clk);
    frm_valid <= 1'b0;
    @(negedge sys_clk);
    chk("sel_valid", 32'h1, {31'h0, sel_valid});
    chk("sel_drop", {31'h0, ed}, {31'h0, sel_drop});
    if (!ed) chk("sel_port", {28'h0, ep}, {28'h0, sel_port});
  endtask : sel

  task automatic ports(input logic [11:0] f, input logic [11:0] hf, input logic [11:0] sl);
    @(posedge sys_clk);
    fail <= f;
    half <= hf;
    slow <= sl;
    repeat (3) @(posedge sys_clk);
  endtask : ports

  function automatic lbd_pkg::lbd_hdr_t mk(input logic [15:0] sm, dm, ip, pt, input logic v4, l4);
    mk = '0;
    mk.smac = {32'h0, sm};
    mk.dmac = {32'h0, dm};
    mk.sip = {16'h0, ip};
    mk.sport = pt;
    mk.ipv4 = v4;
    mk.l4 = l4;
  endfunction : mk

  function automatic logic [7:0] pm(input int p);
    return `LBD_PORT_MAP + 8'(4 * p);
  endfunction : pm

  // ----
  // Tests
  // ----
  initial begin
    repeat (8) @(posedge sys_clk);
    reset_n <= 1'b1;
    @(posedge sys_clk);
    rd(`LBD_HASH_CTRL, 32'hD, `LBD_RESP_OK);
    for (int p = 0; p < 12; p++) rd(pm(p), 32'hF, `LBD_RESP_OK);
    rd(`LBD_BND_CFG, 32'h80, `LBD_RESP_OK);
    rd(8'h80, 32'h0, `LBD_RESP_SLVERR);
    $display("test reset_values done");

    // Bundle configured before the peer is cabled
    for (int p = 0; p < 3; p++) wr(pm(p), 32'h0, `LBD_RESP_OK);
    @(posedge sys_clk);
    cabled <= 1'b1;
    ports(12'h0, 12'h0, 12'h0);
    rd(`LBD_BND_STAT, 32'h0007_0074, `LBD_RESP_OK);
    chk("port_in_bnd", 32'h7, {20'h0, port_in_bnd});
    chk("bnd_up", 32'h1, {27'h0, bnd_up});
    wr(`LBD_BND_STAT, 32'h1, `LBD_RESP_SLVERR);
    $display("test membership done");

    wr(`LBD_HASH_CTRL, 32'h0, `LBD_RESP_OK);
    sel(3'h0, mk(16'h4, 16'h5, 16'h1, 16'h2, 1'b1, 1'b1), 4'h0, 1'b0);
    for (int i = 0; i < 4; i++) begin
      wr(`LBD_HASH_CTRL, 32'h1 << i, `LBD_RESP_OK);
      sel(3'h0, mk(16'h4, 16'h5, 16'h1, 16'h2, 1'b1, 1'b1), 4'(i % 2 + 1), 1'b0);
    end
    sel(3'h0, mk(16'h4, 16'h5, 16'h1, 16'h2, 1'b1, 1'b0), 4'h0, 1'b0);
    wr(`LBD_HASH_CTRL, 32'h4, `LBD_RESP_OK);
    sel(3'h0, mk(16'h4, 16'h5, 16'h1, 16'h2, 1'b0, 1'b0), 4'h0, 1'b0);
    wr(`LBD_HASH_CTRL, 32'h2, `LBD_RESP_OK);
    sel(3'h0, mk(16'h6, 16'h5, 16'h1, 16'h2, 1'b1, 1'b1), 4'h2, 1'b0);
    wr(`LBD_HASH_CTRL, 32'hF, `LBD_RESP_OK);
    repeat (2) sel(3'h0, mk(16'h4, 16'h5, 16'h1, 16'h2, 1'b1, 1'b1), 4'h2, 1'b0);
    // Back-to-back frames of one flow
    @(posedge sys_clk);
    frm_valid <= 1'b1;
    repeat (2) @(posedge sys_clk);
    frm_valid <= 1'b0;
    @(negedge sys_clk);
    chk("sel_port", 32'h2, {28'h0, sel_port});
    $display("test code_fields done");

    wr(`LBD_HASH_CTRL, 32'h4, `LBD_RESP_OK);
    ports(12'h002, 12'h0, 12'h0);
    sel(3'h0, mk(16'h0, 16'h0, 16'h1, 16'h0, 1'b1, 1'b0), 4'h2, 1'b0);
    ports(12'h0, 12'h0, 12'h004);
    rd(`LBD_BND_STAT, 32'h0003_0074, `LBD_RESP_OK);
    sel(3'h0, mk(16'h0, 16'h0, 16'h1, 16'h0, 1'b1, 1'b0), 4'h1, 1'b0);
    ports(12'h0, 12'h002, 12'h0);
    sel(3'h0, mk(16'h0, 16'h0, 16'h1, 16'h0, 1'b1, 1'b0), 4'h2, 1'b0);
    ports(12'h0, 12'h0, 12'h0);
    sel(3'h2, mk(16'h0, 16'h0, 16'h1, 16'h0, 1'b1, 1'b0), 4'h0, 1'b1);
    sel(3'h5, mk(16'h0, 16'h0, 16'h1, 16'h0, 1'b1, 1'b0), 4'h0, 1'b1);
    $display("test link_state done");

    wr(`LBD_MIR_SRC, 32'h1, `LBD_RESP_OK);
    rd(`LBD_MIR_SRC, 32'h0, `LBD_RESP_OK);
    rd(`LBD_STATUS, 32'h1, `LBD_RESP_OK);
    wr(`LBD_STATUS, 32'h1, `LBD_RESP_OK);
    wr(`LBD_MIR_DST, 32'h8, `LBD_RESP_OK);
    wr(pm(3), 32'h0, `LBD_RESP_OK);
    rd(pm(3), 32'hF, `LBD_RESP_OK);
    wr(`LBD_MIR_DST, 32'h0, `LBD_RESP_OK);
    wr(pm(3), 32'h5, `LBD_RESP_OK);
    rd(pm(3), 32'hF, `LBD_RESP_OK);
    wr(pm(3), 32'h7, `LBD_RESP_OK);
    rd(pm(3), 32'hF, `LBD_RESP_OK);
    rd(`LBD_STATUS, 32'h1, `LBD_RESP_OK);
    wr(`LBD_STATUS, 32'h1, `LBD_RESP_OK);
    rd(`LBD_STATUS, 32'h0, `LBD_RESP_OK);
    $display("test rejection done");

    for (int p = 3; p < 6; p++) wr(pm(p), 32'h1, `LBD_RESP_OK);
    wr(`LBD_BND_CFG + 8'h04, 32'h21, `LBD_RESP_OK);
    rd(`LBD_BND_STAT + 8'h04, 32'h0018_0385, `LBD_RESP_OK);
    ports(12'h008, 12'h0, 12'h0);
    rd(`LBD_BND_STAT + 8'h04, 32'h0030_0385, `LBD_RESP_OK);
    sel(3'h1, mk(16'h0, 16'h0, 16'h1, 16'h0, 1'b1, 1'b0), 4'h5, 1'b0);
    ports(12'h0, 12'h0, 12'h0);
    wr(`LBD_BND_CFG + 8'h04, 32'h20, `LBD_RESP_OK);
    rd(`LBD_BND_STAT + 8'h04, 32'h0038_0384, `LBD_RESP_OK);
    $display("test standby done");

    for (int p = 6; p < 12; p++) wr(pm(p), 32'h0, `LBD_RESP_OK);
    wr(pm(3), 32'hF, `LBD_RESP_OK);
    wr(pm(3), 32'h0, `LBD_RESP_OK);
    wr(pm(4), 32'h0, `LBD_RESP_OK);
    rd(pm(4), 32'h1, `LBD_RESP_OK);
    rd(`LBD_BND_STAT, 32'h0FCF_FCF4, `LBD_RESP_OK);
    $display("test member_limit done");
    report_and_stop();
  end

  initial begin
    repeat (6000) @(posedge sys_clk);
    fail_count++;
    report_and_stop();
  end
endmodule : link_bundle_distributor_tb_top
